//--- rtl/switchgear_output_control.sv
`timescale 1ns/10ps
// Function
// - Any status change on channels 4 to 13, except an energy-counting channel 7, raises an event pulse.
// - Each channel drives one signal output and one control output or inhibit.
// - Channel control ignores local/remote selector but still checks interlock.
// - Channel signal output follows channel activity exactly.
// - Channel-triggered open/close pulse length comes from the setting only.
// - Inhibit-configured active channel blocks its selected operation.
// - With interlock disabled, channels cannot inhibit open or close.
// - Channel 7 as energy counter is excluded from events, signals and control; channel_active_o still reports it.
// - Default configuration makes channels plain status inputs.
// - Codes: open 20, close 21, direct-logic 220/221, signals 22 to 24.
// - Open/close accept pushbutton, serial, channel and direct-logic sources.
// - Pushbutton, serial and channel commands pulse only when interlock allows.
// - Pulse lengths 0.1 to 100 s in 0.1 s steps, default 0.1 s.
// - Pulse lengths are taken from the controlled object's channel.
// - Direct command value 0 pulses open, 1 pulses close, if permitted.
// - Arm then execute pulses the armed output; arm clears after execute.
// - Cancel clears a pending arm without any output.
// - Direct-logic open/close is held while its inputs stay unchanged, yielding to any pulse; open beats close.
// - Open/close blockable by interlock result and inhibit channels.
// - Signal outputs driven only by channels and direct logic.
// - Healthy output high with no fault, low on permanent fault.
// - Per-channel polarity selects the active level, active-high default.
module switchgear_output_control
   import switchgear_pkg::*;
(
   // Clock and reset
   input  wire logic                    core_clk_i,
   input  wire logic                    rst_i,
   // Binary input pins, channels 4 to 13
   input  wire logic [NUM_CHANNELS-1:0] channel_pin_i,
   input  wire logic [NUM_CHANNELS-1:0] input_polarity_select_i,
   input  wire channel_cfg_s [NUM_CHANNELS-1:0] channel_cfg_i,
   input  wire logic                    energy_counter_mode_i,
   // Local panel
   input  wire logic                    local_open_button_i,
   input  wire logic                    local_close_button_i,
   input  wire logic                    remote_mode_i,
   // Remote serial commands, one-cycle strobes
   input  wire remote_cmd_s             remote_cmd_i,
   input  wire logic [3:0]              remote_channel_i,
   // Settings
   input  wire logic [3:0]              object_channel_i,
   input  wire logic [3:0]              pulse_channel_i,
   input  wire logic [PULSE_W-1:0]      open_pulse_length_i,
   input  wire logic [PULSE_W-1:0]      close_pulse_length_i,
   input  wire logic                    pulse_length_we_i,
   input  wire logic                    interlock_enable_i,
   input  wire logic                    interlock_bypass_i,
   input  wire logic                    interlock_open_ok_i,
   input  wire logic                    interlock_close_ok_i,
   // Conditional direct output logic results
   input  wire logic                    cdo_open_i,
   input  wire logic                    cdo_close_i,
   input  wire logic [2:0]              cdo_signal_i,
   // Supervision
   input  wire logic                    permanent_fault_i,
   // Outputs
   output logic                         open_o,
   output logic                         close_o,
   output logic [2:0]                   aux_indication_outputs_o,
   output logic                         healthy_indication_output_o,
   output logic                         channel_event_o,
   output logic [NUM_CHANNELS-1:0]      channel_active_o,
   output logic                         armed_open_o,
   output logic                         armed_close_o,
   output logic [PULSE_W-1:0]           open_pulse_length_o,
   output logic [PULSE_W-1:0]           close_pulse_length_o
);

   // Clamp a requested pulse length into the legal range.
   function automatic logic [PULSE_W-1:0] clamp_len(
      input logic [PULSE_W-1:0] len);
      if (len < PULSE_MIN) begin
         return PULSE_MIN;
      end else if (len > PULSE_MAX) begin
         return PULSE_MAX;
      end
      return len;
   endfunction

   logic [NUM_CHANNELS-1:0] pin_meta;
   logic [NUM_CHANNELS-1:0] pin_sync;
   logic [NUM_CHANNELS-1:0] active_now;
   logic [NUM_CHANNELS-1:0] active_prev;
   logic [NUM_CHANNELS-1:0] usable;
   logic [NUM_CHANNELS-1:0] rising;
   logic                    ch_open_req;
   logic                    ch_close_req;
   logic                    inh_open;
   logic                    inh_close;
   logic [2:0]              ch_signal;
   logic                    open_permit;
   logic                    close_permit;
   logic                    remote_ok;
   logic                    req_open;
   logic                    req_close;
   logic [1:0]              button_meta;
   logic [1:0]              button_sync;
   logic [1:0]              button_prev;
   logic                    button_open_edge;
   logic                    button_close_edge;
   logic [TICK_W-1:0]       tick_cnt;
   logic                    tick;
   logic [PULSE_W-1:0]      pulse_cnt;
   pulse_state_e            state;
   pulse_state_e            next_state;
   logic                    cdo_open_eff;
   logic                    cdo_close_eff;

   // Pins come from outside the clock domain.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         // Start at the inactive level so active-low channels see no edge.
         pin_meta <= ~input_polarity_select_i;
         pin_sync <= ~input_polarity_select_i;
      end else begin
         pin_meta <= channel_pin_i;
         pin_sync <= pin_meta;
      end
   end

   assign active_now = ~(pin_sync ^ input_polarity_select_i);

   // An energy-counting channel 7 takes part in nothing else except the channel_active_o status.
   always_comb begin
      usable = '1;
      if (energy_counter_mode_i) begin
         usable[ENERGY_CH_IDX] = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         active_prev     <= '0;
         channel_event_o <= 1'b0;
      end else begin
         active_prev     <= active_now;
         channel_event_o <= |((active_now ^ active_prev) & usable);
      end
   end

   assign channel_active_o = active_prev;
   assign rising           = active_now & ~active_prev & usable;

   // Channel decode; unknown codes, including the default zero, do nothing.
   always_comb begin
      ch_open_req  = 1'b0;
      ch_close_req = 1'b0;
      inh_open     = 1'b0;
      inh_close    = 1'b0;
      ch_signal    = 3'b000;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         if (usable[i] && active_now[i]) begin
            case (channel_cfg_i[i].indication_target)
               CODE_SIG1: ch_signal[0] = 1'b1;
               CODE_SIG2: ch_signal[1] = 1'b1;
               CODE_SIG3: ch_signal[2] = 1'b1;
               default: ;
            endcase
            if (channel_cfg_i[i].inhibit) begin
               if (interlock_enable_i) begin
                  if (channel_cfg_i[i].switch_target == CODE_OPEN) begin
                     inh_open = 1'b1;
                  end
                  if (channel_cfg_i[i].switch_target == CODE_CLOSE) begin
                     inh_close = 1'b1;
                  end
               end
            end else if (rising[i]) begin
               if (channel_cfg_i[i].switch_target == CODE_OPEN) begin
                  ch_open_req = 1'b1;
               end
               if (channel_cfg_i[i].switch_target == CODE_CLOSE) begin
                  ch_close_req = 1'b1;
               end
            end
         end
      end
   end

   // Interlock result only counts when interlocking is enabled and not bypassed.
   assign open_permit  = (!interlock_enable_i || interlock_bypass_i ||
                          interlock_open_ok_i) && !inh_open;
   assign close_permit = (!interlock_enable_i || interlock_bypass_i ||
                          interlock_close_ok_i) && !inh_close;

   assign remote_ok = remote_mode_i && (remote_channel_i == object_channel_i);

   // Pushbuttons are pins as well; bit 0 is open, bit 1 is close.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         button_meta <= '0;
         button_sync <= '0;
         button_prev <= '0;
      end else begin
         button_meta <= {local_close_button_i, local_open_button_i};
         button_sync <= button_meta;
         button_prev <= button_sync;
      end
   end

   assign button_open_edge  = button_sync[0] && !button_prev[0] &&
                              !remote_mode_i;
   assign button_close_edge = button_sync[1] && !button_prev[1] &&
                              !remote_mode_i;

   // Armed state for the secured procedure.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         armed_open_o  <= 1'b0;
         armed_close_o <= 1'b0;
      end else if (remote_ok) begin
         if (remote_cmd_i.cancel || remote_cmd_i.execute) begin
            armed_open_o  <= 1'b0;
            armed_close_o <= 1'b0;
         end else if (remote_cmd_i.arm_open) begin
            armed_open_o  <= 1'b1;
            armed_close_o <= 1'b0;
         end else if (remote_cmd_i.arm_close) begin
            armed_open_o  <= 1'b0;
            armed_close_o <= 1'b1;
         end
      end
   end

   assign req_open = open_permit && (button_open_edge || ch_open_req ||
      (remote_ok && remote_cmd_i.direct_valid &&
       remote_cmd_i.direct_value == DIRECT_OPEN) ||
      (remote_ok && remote_cmd_i.execute && armed_open_o));
   assign req_close = close_permit && (button_close_edge || ch_close_req ||
      (remote_ok && remote_cmd_i.direct_valid &&
       remote_cmd_i.direct_value == DIRECT_CLOSE) ||
      (remote_ok && remote_cmd_i.execute && armed_close_o));

   // Pulse lengths live with the controlled object's channel.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         open_pulse_length_o  <= PULSE_DEFAULT;
         close_pulse_length_o <= PULSE_DEFAULT;
      end else if (pulse_length_we_i &&
                   pulse_channel_i == object_channel_i) begin
         open_pulse_length_o  <= clamp_len(open_pulse_length_i);
         close_pulse_length_o <= clamp_len(close_pulse_length_i);
      end
   end

   // Tick every 0.1 s, restarted with each pulse so the first step is whole.
   always_ff @(posedge core_clk_i) begin
      if (rst_i || state == PULSE_IDLE) begin
         tick_cnt <= '0;
      end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));

   // Open wins a same-cycle tie; the opposite command is lost, not queued.
   always_comb begin
      next_state = state;
      case (state)
         PULSE_IDLE: begin
            if (req_open) begin
               next_state = PULSE_OPEN;
            end else if (req_close) begin
               next_state = PULSE_CLOSE;
            end
         end
         PULSE_OPEN, PULSE_CLOSE: begin
            if (tick && pulse_cnt == PULSE_MIN) begin
               next_state = PULSE_IDLE;
            end
         end
         default: next_state = PULSE_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state <= PULSE_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pulse_cnt <= '0;
      end else if (state == PULSE_IDLE) begin
         if (req_open) begin
            pulse_cnt <= open_pulse_length_o;
         end else if (req_close) begin
            pulse_cnt <= close_pulse_length_o;
         end
      end else if (tick) begin
         pulse_cnt <= pulse_cnt - 1'b1;
      end
   end

   // Direct logic holds its level but bows to a pulse running or starting,
   // so a pulse on one output never meets a held level on the other.
   assign cdo_open_eff  = cdo_open_i && next_state == PULSE_IDLE;
   assign cdo_close_eff = cdo_close_i && !cdo_open_i &&
                          next_state == PULSE_IDLE;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         open_o                      <= 1'b0;
         close_o                     <= 1'b0;
         aux_indication_outputs_o    <= 3'b000;
         healthy_indication_output_o <= 1'b0;
      end else begin
         open_o  <= (next_state == PULSE_OPEN) || cdo_open_eff;
         close_o <= (next_state == PULSE_CLOSE) || cdo_close_eff;
         aux_indication_outputs_o    <= ch_signal | cdo_signal_i;
         healthy_indication_output_o <= !permanent_fault_i;
      end
   end

endmodule

//--- include/switchgear_pkg.sv
package switchgear_pkg;

   // Input channels 4 to 13 are held as a ten-bit vector, bit 0 is channel 4.
   localparam int unsigned NUM_CHANNELS   = 10;
   localparam int unsigned ENERGY_CH_IDX  = 3;
   localparam int unsigned CODE_W         = 8;
   localparam int unsigned PULSE_W        = 10;

   // Output selection codes.
   localparam logic [7:0] CODE_NONE      = 8'h00;
   localparam logic [7:0] CODE_OPEN      = 8'h14;
   localparam logic [7:0] CODE_CLOSE     = 8'h15;
   localparam logic [7:0] CODE_SIG1      = 8'h16;
   localparam logic [7:0] CODE_SIG2      = 8'h17;
   localparam logic [7:0] CODE_SIG3      = 8'h18;
   localparam logic [7:0] CODE_CDO_OPEN  = 8'hdc;
   localparam logic [7:0] CODE_CDO_CLOSE = 8'hdd;

   // Pulse length in tenths of a second: 1 to 1000, default 0.1 s.
   localparam logic [9:0] PULSE_MIN      = 10'h001;
   localparam logic [9:0] PULSE_MAX      = 10'h3e8;
   localparam logic [9:0] PULSE_DEFAULT  = 10'h001;
   localparam logic [3:0] OBJECT_CH_DEFAULT = 4'h2;

   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned TICK_MS       = 100;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TICK_W        = $clog2(TICK_CYCLES);

   // Serial command encodings for the direct switch command value.
   localparam logic DIRECT_OPEN  = 1'b0;
   localparam logic DIRECT_CLOSE = 1'b1;

   typedef struct packed {
      logic direct_valid;
      logic direct_value;
      logic arm_open;
      logic arm_close;
      logic execute;
      logic cancel;
   } remote_cmd_s;

   typedef struct packed {
      logic [CODE_W-1:0] indication_target;
      logic [CODE_W-1:0] switch_target;
      logic              inhibit;
   } channel_cfg_s;

   typedef enum logic [2:0] {
      PULSE_IDLE  = 3'b001,
      PULSE_OPEN  = 3'b010,
      PULSE_CLOSE = 3'b100
   } pulse_state_e;

endpackage

//--- testbench/switchgear_asserts.sv
`timescale 1ns/10ps
module switchgear_asserts
   import switchgear_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire remote_cmd_s remote_cmd_i,
   input  wire logic [3:0]  remote_channel_i,
   input  wire logic [3:0]  object_channel_i,
   input  wire logic        remote_mode_i,
   input  wire logic        interlock_enable_i,
   input  wire logic        interlock_bypass_i,
   input  wire logic        interlock_close_ok_i,
   input  wire logic        cdo_open_i,
   input  wire logic        cdo_close_i,
   input  wire logic [2:0]  cdo_signal_i,
   input  wire logic        permanent_fault_i,
   input  wire logic        open_o,
   input  wire logic        close_o,
   input  wire logic [2:0]  aux_indication_outputs_o,
   input  wire logic        healthy_indication_output_o,
   input  wire logic        armed_open_o,
   input  wire logic        armed_close_o
);
   // A serial strobe only counts when addressed and in remote mode; taken also needs open, close and direct logic idle.
   logic addressed;
   logic taken;
   assign addressed = remote_mode_i && remote_channel_i == object_channel_i;
   assign taken = addressed && !open_o && !close_o && !cdo_open_i
      && !cdo_close_i;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   AST_EXCL: assert property (
      !(open_o && close_o)) else $error("open and close high together");
   AST_DIR_OPEN: assert property (
      taken && remote_cmd_i.direct_valid && !remote_cmd_i.direct_value
      && !interlock_enable_i |=> open_o) else $error("no open pulse");
   AST_DIR_CLOSE: assert property (
      taken && remote_cmd_i.direct_valid && remote_cmd_i.direct_value
      && !interlock_enable_i |=> close_o && !open_o)
      else $error("no close pulse");
   AST_BLOCK: assert property (
      taken && remote_cmd_i.direct_valid && remote_cmd_i.direct_value
      && interlock_enable_i && !interlock_bypass_i && !interlock_close_ok_i
      |=> !close_o) else $error("close not blocked by interlock");
   AST_HOLD: assert property (
      $rose(open_o) && !cdo_open_i |=> open_o [*8])
      else $error("open pulse ended early");
   AST_HEALTH: assert property (
      permanent_fault_i |=> !healthy_indication_output_o)
      else $error("healthy output stayed high on fault");
   AST_ARM: assert property (
      taken && remote_cmd_i.arm_open && !remote_cmd_i.execute
      && !remote_cmd_i.cancel |=> armed_open_o) else $error("arm lost");
   AST_DISARM: assert property (
      addressed && (remote_cmd_i.execute || remote_cmd_i.cancel)
      && !remote_cmd_i.arm_open && !remote_cmd_i.arm_close
      |=> !armed_open_o && !armed_close_o) else $error("arm not cleared");
   AST_CANCEL: assert property (
      taken && remote_cmd_i.cancel && !remote_cmd_i.execute
      && !remote_cmd_i.direct_valid |=> !open_o && !close_o)
      else $error("cancel produced output");
   AST_SIG: assert property (
      cdo_signal_i[1] |-> ##[1:2] aux_indication_outputs_o[1])
      else $error("signal output not driven");
endmodule
bind switchgear_output_control switchgear_asserts chk (.core_clk_i,
   .rst_i, .remote_cmd_i, .remote_channel_i, .object_channel_i,
   .remote_mode_i, .interlock_enable_i, .interlock_bypass_i,
   .interlock_close_ok_i, .cdo_open_i, .cdo_close_i, .cdo_signal_i,
   .permanent_fault_i, .open_o, .close_o, .aux_indication_outputs_o,
   .healthy_indication_output_o, .armed_open_o, .armed_close_o);

//--- testbench/remote_station.sv
`timescale 1ns/10ps
module remote_station
   import switchgear_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       go_i,
   input  wire logic [2:0] op_i,
   output remote_cmd_s     remote_cmd_o,
   output logic [3:0]      remote_channel_o
);
   // Commands always go to the channel that holds the controlled object.
   assign remote_channel_o = OBJECT_CH_DEFAULT;
   // Every command is a single strobe cycle launched just after an edge.
   always_ff @(posedge core_clk_i) begin
      remote_cmd_o <= '0;
      if (go_i) begin
         case (op_i)
            3'h0: remote_cmd_o <= 6'h20;
            3'h1: remote_cmd_o <= 6'h30;
            3'h2: remote_cmd_o <= 6'h08;
            3'h3: remote_cmd_o <= 6'h04;
            3'h4: remote_cmd_o <= 6'h02;
            3'h5: remote_cmd_o <= 6'h01;
            default: remote_cmd_o <= '0;
         endcase
      end
   end
endmodule

//--- testbench/tb.sv
`timescale 1ns/10ps
module tb;
   import switchgear_pkg::*;
   logic core_clk_i = 0, rst_i = 1, go = 0, seen;
   logic [2:0] op = 0, cdo_signal_i = 0, aux_indication_outputs_o;
   logic [9:0] channel_pin_i = 0, input_polarity_select_i = '1;
   logic [9:0] channel_active_o, open_pulse_length_o, close_pulse_length_o;
   logic [9:0] open_pulse_length_i = 1, close_pulse_length_i = 1;
   logic [3:0] object_channel_i = OBJECT_CH_DEFAULT, remote_channel_i;
   logic [3:0] pulse_channel_i = OBJECT_CH_DEFAULT;
   channel_cfg_s [NUM_CHANNELS-1:0] channel_cfg_i = '0;
   remote_cmd_s remote_cmd_i;
   logic energy_counter_mode_i = 0, local_open_button_i = 0;
   logic local_close_button_i = 0, remote_mode_i = 1, pulse_length_we_i = 0;
   logic interlock_enable_i = 0, interlock_bypass_i = 0;
   logic interlock_open_ok_i = 1, interlock_close_ok_i = 1;
   logic cdo_open_i = 0, cdo_close_i = 0, permanent_fault_i = 0;
   logic open_o, close_o, healthy_indication_output_o, channel_event_o;
   logic armed_open_o, armed_close_o;
   int n_errors = 0, num_checks = 0, cycles = 0;
   initial forever #5 core_clk_i = ~core_clk_i;
   remote_station peer (.core_clk_i, .go_i(go), .op_i(op),
      .remote_cmd_o(remote_cmd_i), .remote_channel_o(remote_channel_i));
   switchgear_output_control uut (.core_clk_i, .rst_i, .channel_pin_i,
      .input_polarity_select_i, .channel_cfg_i, .energy_counter_mode_i,
      .local_open_button_i, .local_close_button_i, .remote_mode_i,
      .remote_cmd_i, .remote_channel_i, .object_channel_i, .pulse_channel_i,
      .open_pulse_length_i, .close_pulse_length_i, .pulse_length_we_i,
      .interlock_enable_i, .interlock_bypass_i, .interlock_open_ok_i,
      .interlock_close_ok_i, .cdo_open_i, .cdo_close_i, .cdo_signal_i,
      .permanent_fault_i, .open_o, .close_o, .aux_indication_outputs_o,
      .healthy_indication_output_o, .channel_event_o, .channel_active_o,
      .armed_open_o, .armed_close_o, .open_pulse_length_o,
      .close_pulse_length_o);
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Pulses last ten million cycles or more, so each scenario ends by reset.
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic check(string what, logic [9:0] exp, logic [9:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task automatic do_reset();
      rst_i = 1;
      channel_pin_i = 0;
      channel_cfg_i = '0;
      interlock_enable_i = 0;
      interlock_close_ok_i = 1;
      cdo_open_i = 0;
      cdo_signal_i = 0;
      remote_mode_i = 1;
      local_open_button_i = 0;
      energy_counter_mode_i = 0;
      input_polarity_select_i = '1;
      cyc(6);
      rst_i = 0;
      cyc(1);
   endtask
   task automatic send(logic [2:0] code);
      go = 1;
      op = code;
      cyc(1);
      go = 0;
      cyc(1);
   endtask
   task automatic t_direct();
      for (int v = 0; v < 2; v++) begin
         do_reset();
         check("healthy", 1, healthy_indication_output_o);
         check("open len", 1, open_pulse_length_o);
         send(3'(v));
         check("open", 10'(v == 0), open_o);
         check("close", 10'(v), close_o);
         send(3'(1 - v));
         check("busy open", 10'(v == 0), open_o);
         check("busy close", 10'(v), close_o);
      end
   endtask
   task automatic t_secured();
      do_reset();
      send(3'h3);
      check("armed close", 1, armed_close_o);
      send(3'h4);
      check("exec close", 1, close_o);
      check("arm after exec", 0, armed_close_o);
      do_reset();
      send(3'h2);
      send(3'h5);
      check("arm after cancel", 0, armed_open_o);
      check("cancel open", 0, open_o);
   endtask
   task automatic t_interlock();
      do_reset();
      interlock_enable_i = 1;
      interlock_close_ok_i = 0;
      send(3'h1);
      check("blocked close", 0, close_o);
      interlock_close_ok_i = 1;
      send(3'h1);
      check("permitted close", 1, close_o);
   endtask
   task automatic t_channel();
      seen = 0;
      do_reset();
      channel_cfg_i[0] = '{CODE_SIG1, CODE_OPEN, 1'b0};
      channel_pin_i[0] = 1;
      for (int i = 0; i < 8 && !seen; i++) begin
         cyc(1);
         seen = channel_event_o === 1'b1;
      end
      check("event", 1, seen);
      cyc(2);
      check("chan open", 1, open_o);
      check("chan signal", 1, aux_indication_outputs_o);
      check("chan active", 1, channel_active_o);
      channel_pin_i[0] = 0;
      cyc(5);
      check("signal off", 0, aux_indication_outputs_o);
      check("pulse held", 1, open_o);
   endtask
   task automatic t_inhibit();
      for (int en = 1; en >= 0; en--) begin
         do_reset();
         interlock_enable_i = 1'(en);
         channel_cfg_i[1] = '{CODE_NONE, CODE_CLOSE, 1'b1};
         channel_pin_i[1] = 1;
         cyc(5);
         send(3'h1);
         check("inhibited close", 10'(en == 0), close_o);
      end
   endtask
   task automatic t_misc();
      do_reset();
      cdo_open_i = 1;
      cdo_signal_i = 3'h6;
      cyc(8);
      check("logic open", 1, open_o);
      check("logic signal", 6, aux_indication_outputs_o);
      cdo_open_i = 0;
      cyc(3);
      check("logic open off", 0, open_o);
      do_reset();
      remote_mode_i = 0;
      send(3'h0);
      check("serial in local", 0, open_o);
      local_open_button_i = 1;
      cyc(3);
      check("button open", 1, open_o);
      open_pulse_length_i = 10'h005;
      close_pulse_length_i = 10'h3ff;
      pulse_length_we_i = 1;
      cyc(1);
      pulse_length_we_i = 0;
      cyc(1);
      check("open len set", 5, open_pulse_length_o);
      check("close len clamp", PULSE_MAX, close_pulse_length_o);
      permanent_fault_i = 1;
      cyc(2);
      check("fault", 0, healthy_indication_output_o);
      permanent_fault_i = 0;
   endtask
   task automatic t_config();
      do_reset();
      energy_counter_mode_i = 1;
      input_polarity_select_i[2] = 0;
      channel_cfg_i[3] = '{CODE_SIG2, CODE_OPEN, 1'b0};
      channel_cfg_i[2] = '{CODE_SIG3, CODE_NONE, 1'b0};
      channel_pin_i[3] = 1;
      cyc(5);
      check("energy ch open", 0, open_o);
      check("low active sig", 4, aux_indication_outputs_o);
      pulse_channel_i = 4'h3;
      open_pulse_length_i = 10'h007;
      pulse_length_we_i = 1;
      cyc(1);
      pulse_length_we_i = 0;
      pulse_channel_i = OBJECT_CH_DEFAULT;
      cyc(1);
      check("foreign len", 1, open_pulse_length_o);
   endtask
   initial begin
      t_direct();
      t_secured();
      t_interlock();
      t_channel();
      t_inhibit();
      t_misc();
      t_config();
      print_verdict();
   end
endmodule
